//--- hw/timer_capture_core.v
// What this block does
// RQ1: Sixteen-bit counter, plus one per tick
// RQ2: Two-bit field picks tap or pin
// RQ3: Run bit counts; stopped counter reads zero
// RQ4: Clear-on-match against compare B, else free
// RQ5: Overflow raises timer interrupt A
// RQ6: Two compare registers with equality comparators
// RQ7: Match A irq A, match B irq B
// RQ8: Shadow buffers, off at reset, enable bit
// RQ9: Buffered values load on match B
// RQ10: Stopped counter makes compare writes immediate
// RQ11: Two-bit field picks hardware capture events
// RQ12: Writing zero to soft bit captures A
// RQ13: Readback register shows live count
// RQ14: Four enabled sources toggle the flip-flop
// RQ15: Flip-flop has no reset value
// RQ16: Command field toggles, sets or clears
// RQ17: Flip-flop drives pin when port enabled
// RQ18: Each capture raises its own interrupt
// RQ19: Software keeps tap slower than system clock
// RQ20: Software keeps gear fixed while counting
// RQ21: Software avoids prohibited tap settings
// RQ22: Taps divide by two, eight, thirty-two
// RQ23: Pin synchronised, counts rising edges
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`include "timer_capture_consts.vh"
`default_nettype none

module timer_capture_core (
  // Clock and reset
  input wire mclk_in,
  input wire sys_rst_in,
  // Register port
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  // Pins
  input wire external_count_pin_in,
  input wire capture_pin_in,
  output reg timer_output_pin_out,
  output reg timer_output_oe_n_out,
  // Interrupt pulses
  output reg timer_irq_a_out,
  output reg timer_irq_b_out,
  output reg capture_irq_a_out,
  output reg capture_irq_b_out
);

  // ********************************************************
  // Registers
  // ********************************************************
  // Software-written control state
  reg count_run_bit_r;
  reg write_buffer_en_r;
  reg [7:0] timer_mode_reg_r;
  reg [7:0] toggle_ff_control_reg_r;
  reg port_out_en_r;

  // Compare values and their shadows
  reg [15:0] compare_reg_a_r;
  reg [15:0] compare_reg_b_r;
  reg [15:0] shadow_a_r;
  reg [15:0] shadow_b_r;

  // Live and captured counts
  reg [15:0] capture_reg_a_r;
  reg [15:0] capture_reg_b_r;
  reg [15:0] up_counter_r;

  // Prescaler, pin synchronisers and the timer flip-flop
  reg timer_toggle_ff_r;
  reg [4:0] prescale_r;
  reg [2:0] ext_sync_r;
  reg [2:0] cap_sync_r;

  // Named views of the packed mode and toggle fields
  wire [1:0] count_source_sel = timer_mode_reg_r[`MOD_SRC_HI:`MOD_SRC_LO];
  wire clear_on_match_en = timer_mode_reg_r[`BIT_CLEAR_MATCH];
  wire [1:0] capture_timing_sel = timer_mode_reg_r[`MOD_CAPSEL_HI:`MOD_CAPSEL_LO];
  wire toggle_on_match_a_en = toggle_ff_control_reg_r[`BIT_TGL_MATCH_A];
  wire toggle_on_match_b_en = toggle_ff_control_reg_r[`BIT_TGL_MATCH_B];
  wire toggle_on_capture_a_en = toggle_ff_control_reg_r[`BIT_TGL_CAP_A];
  wire toggle_on_capture_b_en = toggle_ff_control_reg_r[`BIT_TGL_CAP_B];

  // One-cycle write decodes; unmapped indices match none of them,
  // so writes there are dropped without side effects
  wire wr_run = reg_wr_in && (reg_addr_in == `OFS_RUN_CONTROL);
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `OFS_TIMER_CONTROL);
  wire wr_mode = reg_wr_in && (reg_addr_in == `OFS_TIMER_MODE);
  wire wr_tgl = reg_wr_in && (reg_addr_in == `OFS_TOGGLE_CTRL);
  wire wr_cmp_a = reg_wr_in && (reg_addr_in == `OFS_COMPARE_A);
  wire wr_cmp_b = reg_wr_in && (reg_addr_in == `OFS_COMPARE_B);
  wire wr_port = reg_wr_in && (reg_addr_in == `OFS_PORT_FUNC);

  // ********************************************************
  // Input synchronisers and edge detection
  // ********************************************************
  // Stage 0 feeds only stage 1; edges are taken between stages 1 and 2
  // Pin pulses shorter than one clock may be missed altogether
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ext_sync_r <= 3'h0;
      cap_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], external_count_pin_in}; // RQ23
      cap_sync_r <= {cap_sync_r[1:0], capture_pin_in};
    end
  end

  // Edge pulses last one cycle, so a slow pin edge is seen once;
  // the pin can be counted at most once per two clocks
  wire ext_rise = ext_sync_r[1] && !ext_sync_r[2]; // RQ23
  wire cap_rise = cap_sync_r[1] && !cap_sync_r[2];
  wire cap_fall = !cap_sync_r[1] && cap_sync_r[2];

  // ********************************************************
  // Prescaler and tick select
  // ********************************************************
  // Free-running so tap phase does not depend on run timing
  // It keeps running while the counter is stopped
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      prescale_r <= 5'h00;
    end else begin
      prescale_r <= prescale_r + 5'h01;
    end
  end

  // One tick per tap period; the mask test keeps all taps in step
  // with the free-running prescaler
  reg tick;
  always @* begin
    case (count_source_sel) // RQ2
      `SRC_DIV1: tick = ((prescale_r & `DIV1_LAST) == `DIV1_LAST); // RQ22
      `SRC_DIV4: tick = ((prescale_r & `DIV4_LAST) == `DIV4_LAST); // RQ22
      `SRC_DIV16: tick = ((prescale_r & `DIV16_LAST) == `DIV16_LAST); // RQ22
      default: tick = ext_rise; // RQ23
    endcase
  end

  // ********************************************************
  // Comparators
  // ********************************************************
  // Raw equality, used both for events and for the clear decision
  wire match_a = (up_counter_r == compare_reg_a_r); // RQ6
  wire match_b = (up_counter_r == compare_reg_b_r); // RQ6
  // Match events are qualified by a tick so a held value fires once
  wire match_a_ev = count_run_bit_r && tick && match_a;
  wire match_b_ev = count_run_bit_r && tick && match_b;
  // A wrap and a clear at the top count cannot both happen;
  // the clear wins, so no overflow is reported then
  wire at_top = (up_counter_r == `COUNT_MAX);
  wire overflow_ev = count_run_bit_r && tick && at_top && !(clear_on_match_en && match_b);

  // ********************************************************
  // Up-counter
  // ********************************************************
  // Stopping clears at once, so a restart always begins from zero;
  // ticks between a stop and the next start are ignored
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      up_counter_r <= `COUNT_ZERO;
    end else if (!count_run_bit_r) begin
      up_counter_r <= `COUNT_ZERO; // RQ3
    end else if (tick) begin
      if (clear_on_match_en && match_b) begin
        up_counter_r <= `COUNT_ZERO; // RQ4
      end else begin
        up_counter_r <= up_counter_r + 16'h0001; // RQ1
      end
    end
  end

  // ********************************************************
  // Control registers
  // ********************************************************
  // Software-visible control bits; each register is written whole,
  // so software must write back the fields it wants to keep
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      count_run_bit_r <= 1'b0;
      write_buffer_en_r <= 1'b0; // RQ8
      timer_mode_reg_r <= `MODE_RESET;
      toggle_ff_control_reg_r <= `TOGGLE_RESET;
      port_out_en_r <= 1'b0;
    end else begin
      if (wr_run) begin
        count_run_bit_r <= reg_wdata_in[`BIT_RUN]; // RQ3
      end
      if (wr_ctrl) begin
        write_buffer_en_r <= reg_wdata_in[`BIT_WBUF_EN]; // RQ8
      end
      if (wr_mode) begin
        // Soft capture bit always reads back as one
        timer_mode_reg_r <= reg_wdata_in[7:0] | `MODE_RESET;
      end
      if (wr_tgl) begin
        // Command field is an action, it reads back as no-op
        toggle_ff_control_reg_r <= {reg_wdata_in[7:2], `FF_CMD_NONE};
      end
      if (wr_port) begin
        port_out_en_r <= reg_wdata_in[`BIT_PORT_OUT_EN];
      end
    end
  end

  // ********************************************************
  // Compare registers and shadow buffers
  // ********************************************************
  // Buffered only while running; a stopped timer writes straight through
  wire buffered = write_buffer_en_r && count_run_bit_r;
  // Shadows follow every write, so enabling buffering later starts
  // from the values software last wrote, not from stale ones
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      compare_reg_a_r <= `COUNT_ZERO;
      compare_reg_b_r <= `COUNT_ZERO;
      shadow_a_r <= `COUNT_ZERO;
      shadow_b_r <= `COUNT_ZERO;
    end else begin
      if (wr_cmp_a) begin
        shadow_a_r <= reg_wdata_in;
      end
      if (wr_cmp_b) begin
        shadow_b_r <= reg_wdata_in;
      end
      if (!buffered) begin
        if (wr_cmp_a) begin
          compare_reg_a_r <= reg_wdata_in; // RQ10
        end
        if (wr_cmp_b) begin
          compare_reg_b_r <= reg_wdata_in; // RQ10
        end
      end else if (match_b_ev) begin
        compare_reg_a_r <= shadow_a_r; // RQ9
        compare_reg_b_r <= shadow_b_r; // RQ9
      end
    end
  end

  // ********************************************************
  // Capture
  // ********************************************************
  // Soft capture acts on the mode write itself, whatever the capture
  // field says; writing one to the bit does nothing
  wire soft_capture_trigger = wr_mode && !reg_wdata_in[`BIT_SOFT_CAPTURE];
  reg hw_cap_a;
  reg hw_cap_b;
  // Hardware capture sources for each capture timing code
  always @* begin
    case (capture_timing_sel) // RQ11
      `CAP_EXT_RISE: begin
        hw_cap_a = cap_rise;
        hw_cap_b = 1'b0;
      end
      `CAP_EXT_BOTH: begin
        hw_cap_a = cap_rise;
        hw_cap_b = cap_fall;
      end
      `CAP_MATCH_A: begin
        hw_cap_a = match_a_ev;
        hw_cap_b = match_b_ev;
      end
      default: begin
        hw_cap_a = 1'b0;
        hw_cap_b = 1'b0;
      end
    endcase
  end
  // Soft and hardware capture into A merge; they latch the same count
  wire cap_a_ev = hw_cap_a || soft_capture_trigger; // RQ12
  wire cap_b_ev = hw_cap_b;

  // Capture latches the count as it stood before the triggering edge
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      capture_reg_a_r <= `COUNT_ZERO;
      capture_reg_b_r <= `COUNT_ZERO;
    end else begin
      if (cap_a_ev) begin
        capture_reg_a_r <= up_counter_r; // RQ12
      end
      if (cap_b_ev) begin
        capture_reg_b_r <= up_counter_r; // RQ11
      end
    end
  end

  // ********************************************************
  // Timer flip-flop
  // ********************************************************
  // No reset branch: the level is undefined until software commands it
  // The command field reads back as no-op, so decode it from the write data
  wire [1:0] ff_cmd = reg_wdata_in[`FFC_CMD_HI:`FFC_CMD_LO];
  // Sources that fire in one cycle cancel in pairs; software that
  // wants every event seen should enable only one of them
  wire tgl_match_a = toggle_on_match_a_en && match_a_ev;
  wire tgl_match_b = toggle_on_match_b_en && match_b_ev;
  wire tgl_cap_a = toggle_on_capture_a_en && cap_a_ev;
  wire tgl_cap_b = toggle_on_capture_b_en && cap_b_ev;
  wire hw_toggle = tgl_match_a ^ tgl_match_b ^ tgl_cap_a ^ tgl_cap_b; // RQ14
  always @(posedge mclk_in) begin // RQ15
    if (wr_tgl && ff_cmd == `FF_CMD_SET) begin
      timer_toggle_ff_r <= 1'b1; // RQ16
    end else if (wr_tgl && ff_cmd == `FF_CMD_CLEAR) begin
      timer_toggle_ff_r <= 1'b0; // RQ16
    end else if ((wr_tgl && ff_cmd == `FF_CMD_TOGGLE) ^ hw_toggle) begin
      timer_toggle_ff_r <= !timer_toggle_ff_r; // RQ14 RQ16
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // Interrupts are one-cycle pulses; an interrupt controller that
  // samples levels must latch them
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      timer_output_pin_out <= 1'b0;
      timer_output_oe_n_out <= 1'b1;
      timer_irq_a_out <= 1'b0;
      timer_irq_b_out <= 1'b0;
      capture_irq_a_out <= 1'b0;
      capture_irq_b_out <= 1'b0;
    end else begin
      // Gated until the port is set up, so the undefined level cannot reach the pin while the port is off
      timer_output_pin_out <= port_out_en_r & timer_toggle_ff_r; // RQ17
      timer_output_oe_n_out <= !port_out_en_r; // RQ17
      timer_irq_a_out <= match_a_ev || overflow_ev; // RQ5 RQ7
      timer_irq_b_out <= match_b_ev; // RQ7
      capture_irq_a_out <= cap_a_ev; // RQ18
      capture_irq_b_out <= cap_b_ev; // RQ18
    end
  end

  // ********************************************************
  // Register read
  // ********************************************************
  // Read mux; fields narrower than the bus read zero above them,
  // and the soft capture bit always reads one
  reg [15:0] rd_nxt;
  always @* begin
    case (reg_addr_in)
      `OFS_RUN_CONTROL: rd_nxt = {15'h0000, count_run_bit_r};
      `OFS_TIMER_CONTROL: rd_nxt = {8'h00, write_buffer_en_r, 7'h00};
      `OFS_TIMER_MODE: rd_nxt = {8'h00, timer_mode_reg_r};
      `OFS_TOGGLE_CTRL: rd_nxt = {8'h00, toggle_ff_control_reg_r};
      `OFS_COMPARE_A: rd_nxt = compare_reg_a_r;
      `OFS_COMPARE_B: rd_nxt = compare_reg_b_r;
      `OFS_CAPTURE_A: rd_nxt = capture_reg_a_r;
      `OFS_CAPTURE_B: rd_nxt = capture_reg_b_r;
      `OFS_COUNT_READ: rd_nxt = up_counter_r; // RQ13
      `OFS_PORT_FUNC: rd_nxt = {15'h0000, port_out_en_r};
      default: rd_nxt = 16'h0000;
    endcase
  end

  // Read data stands for one cycle only and is zero otherwise, so
  // a late sample by the master reads zero rather than stale data
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_nxt;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

//--- hw/timer_capture_consts.vh
`ifndef TIMER_CAPTURE_CONSTS_VH
`define TIMER_CAPTURE_CONSTS_VH

// ********************************************************
// Register offsets (word index on the plain port)
// ********************************************************
`define OFS_RUN_CONTROL   4'h0
`define OFS_TIMER_CONTROL 4'h1
`define OFS_TIMER_MODE    4'h2
`define OFS_TOGGLE_CTRL   4'h3
`define OFS_COMPARE_A     4'h4
`define OFS_COMPARE_B     4'h5
`define OFS_CAPTURE_A     4'h6
`define OFS_CAPTURE_B     4'h7
`define OFS_COUNT_READ    4'h8
`define OFS_PORT_FUNC     4'h9

// ********************************************************
// Field positions
// ********************************************************
`define BIT_RUN           0
`define BIT_WBUF_EN       7
`define MOD_SRC_LO        0
`define MOD_SRC_HI        1
`define BIT_CLEAR_MATCH   2
`define MOD_CAPSEL_LO     3
`define MOD_CAPSEL_HI     4
`define BIT_SOFT_CAPTURE  6
`define FFC_CMD_LO        0
`define FFC_CMD_HI        1
`define BIT_TGL_MATCH_A   2
`define BIT_TGL_MATCH_B   3
`define BIT_TGL_CAP_A     4
`define BIT_TGL_CAP_B     5
`define BIT_PORT_OUT_EN   0

// ********************************************************
// Encodings and reset values
// ********************************************************
`define SRC_EXT           2'h0
`define SRC_DIV1          2'h1
`define SRC_DIV4          2'h2
`define SRC_DIV16         2'h3
`define CAP_OFF           2'h0
`define CAP_EXT_RISE      2'h1
`define CAP_EXT_BOTH      2'h2
`define CAP_MATCH_A       2'h3
`define FF_CMD_TOGGLE     2'h0
`define FF_CMD_SET        2'h1
`define FF_CMD_CLEAR      2'h2
`define FF_CMD_NONE       2'h3
`define MODE_RESET        8'h40
`define TOGGLE_RESET      8'h03
`define COUNT_ZERO        16'h0000
`define COUNT_MAX         16'hffff
`define DIV1_LAST         5'h01
`define DIV4_LAST         5'h07
`define DIV16_LAST        5'h1f

`endif

//--- tb/timer_capture_asserts.sv
`default_nettype none
// ****************************************
// Port checker for the timer core
// ****************************************
module timer_capture_asserts (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // Pins and interrupts
  input wire logic timer_output_pin_out,
  input wire logic timer_output_oe_n_out,
  input wire logic timer_irq_a_out,
  input wire logic timer_irq_b_out,
  input wire logic capture_irq_a_out,
  input wire logic capture_irq_b_out
);
  logic run_r;
  logic en_r;
  logic [1:0] capsel_r;
  // Mirror of the few software bits the properties need
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      run_r <= 1'b0;
      en_r <= 1'b0;
      capsel_r <= 2'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 4'h0) run_r <= reg_wdata_in[0];
      if (reg_addr_in == 4'h9) en_r <= reg_wdata_in[0];
      if (reg_addr_in == 4'h2) capsel_r <= reg_wdata_in[4:3];
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // Stopped for three samples, so late pulses from the last tick are excluded
  stop_quiet_a: assert property (!run_r && !$past(run_r) && !$past(run_r, 2) |-> !timer_irq_a_out && !timer_irq_b_out)
    else $error("interrupt while stopped");
  stop_zero_a: assert property (reg_rd_in && reg_addr_in == 4'h8 && !run_r && !$past(run_r) |=> reg_rdata_out == 16'h0000)
    else $error("stopped count not zero");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in > 4'h9 |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  match_pulse_a: assert property (timer_irq_b_out |=> !timer_irq_b_out)
    else $error("match interrupt too long");
  soft_cap_a: assert property (reg_wr_in && reg_addr_in == 4'h2 && !reg_wdata_in[6] |-> ##[1:2] capture_irq_a_out)
    else $error("soft capture gave no interrupt");
  cap_b_mode_a: assert property (capture_irq_b_out |-> $past(capsel_r) >= 2'h2)
    else $error("capture b outside its modes");
  oe_follow_a: assert property (en_r == $past(en_r) |-> timer_output_oe_n_out == !en_r)
    else $error("output enable wrong");
  pin_masked_a: assert property (timer_output_oe_n_out |-> !timer_output_pin_out)
    else $error("pin driven while disabled");
  ff_cmd_a: assert property (reg_wr_in && reg_addr_in == 4'h3 && reg_wdata_in[5:2] == 4'h0 && en_r
    && (reg_wdata_in[1:0] == 2'h1 || reg_wdata_in[1:0] == 2'h2)
    |-> ##2 timer_output_pin_out == $past(reg_wdata_in[0], 2))
    else $error("set or clear command ignored");
  // Main scenarios
  match_b_c: cover property (timer_irq_b_out);
  match_a_c: cover property (timer_irq_a_out);
  cap_b_c: cover property (capture_irq_b_out);
endmodule
bind timer_capture_core timer_capture_asserts chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .timer_output_pin_out(timer_output_pin_out),
  .timer_output_oe_n_out(timer_output_oe_n_out), .timer_irq_a_out(timer_irq_a_out),
  .timer_irq_b_out(timer_irq_b_out), .capture_irq_a_out(capture_irq_a_out), .capture_irq_b_out(capture_irq_b_out));
`default_nettype wire

//--- tb/timer_capture_core_tb.sv
`default_nettype none
// ****************************************
// Self-checking bench for the timer core
// ****************************************
module timer_capture_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic ext_pin = 1'b0;
  logic cap_pin = 1'b0;
  wire [15:0] reg_rdata_out;
  wire pin_out, oe_n_out, tia, tib, cia, cib;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  logic [15:0] d, c;
  logic p;
  // Rows: source select and irq b spacing for compare b of 3
  logic [1:0] row_src [3] = '{2'h1, 2'h2, 2'h3};
  int row_gap [3] = '{8, 32, 128};
  timer_capture_core dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .external_count_pin_in(ext_pin), .capture_pin_in(cap_pin), .timer_output_pin_out(pin_out),
    .timer_output_oe_n_out(oe_n_out), .timer_irq_a_out(tia), .timer_irq_b_out(tib),
    .capture_irq_a_out(cia), .capture_irq_b_out(cib));
  always #10 mclk_in = ~mclk_in;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bus cycles start right after an edge; an idle edge follows so strobes never collide
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(posedge mclk_in);
    v = reg_rdata_out;
  endtask
  task automatic wait_irq(input int sel, output int k);
    logic [3:0] v;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
      v = {cib, cia, tib, tia};
    end while (v[sel] !== 1'b1 && k < 2000);
  endtask
  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    rd(4'h2, d); check(d, 16'h0040);
    rd(4'h3, d); check(d, 16'h0003);
    rd(4'h8, d); check(d, 16'h0000);
    rd(4'hf, d); check(d, 16'h0000);
    $display("reset values done");
    foreach (row_src[i]) begin
      wr(4'h0, 16'h0000);
      wr(4'h5, 16'h0003);
      wr(4'h2, {14'h0011, row_src[i]});
      wr(4'h0, 16'h0001);
      wait_irq(1, n);
      wait_irq(1, n);
      check(16'(n), 16'(row_gap[i]));
      wait_irq(0, n);
      wait_irq(0, n);
      check(16'(n), 16'(row_gap[i]));
    end
    $display("source rows done");
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0080);
    wr(4'h4, 16'h1234);
    rd(4'h4, d); check(d, 16'h1234);
    wr(4'h5, 16'h0100);
    wr(4'h2, 16'h0045);
    wr(4'h0, 16'h0001);
    wr(4'h4, 16'h0055);
    rd(4'h4, d); check(d, 16'h1234);
    wait_irq(1, n);
    rd(4'h4, d); check(d, 16'h0055);
    wr(4'h1, 16'h0000);
    $display("buffering done");
    // A small lag is allowed: the counter keeps moving between the two reads
    wr(4'h2, 16'h0005);
    rd(4'h6, c);
    rd(4'h8, d);
    check(16'(d - c <= 16'h0004), 16'h0001);
    $display("soft capture done");
    wr(4'h9, 16'h0001);
    wr(4'h3, 16'h0001); @(posedge mclk_in); check(16'(pin_out), 16'h0001);
    check(16'(oe_n_out), 16'h0000);
    wr(4'h3, 16'h0002); @(posedge mclk_in); check(16'(pin_out), 16'h0000);
    wr(4'h3, 16'h0000); @(posedge mclk_in); check(16'(pin_out), 16'h0001);
    wr(4'h3, 16'h000b);
    p = pin_out;
    wait_irq(1, n);
    repeat (2) @(posedge mclk_in);
    check(16'(pin_out), 16'(!p));
    wr(4'h3, 16'h0003);
    $display("flip-flop done");
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0050);
    wr(4'h0, 16'h0001);
    repeat (5) begin
      ext_pin <= 1'b1;
      repeat (3) @(posedge mclk_in);
      ext_pin <= 1'b0;
      repeat (3) @(posedge mclk_in);
    end
    rd(4'h8, d); check(d, 16'h0005);
    cap_pin <= 1'b1;
    wait_irq(2, n);
    cap_pin <= 1'b0;
    wait_irq(3, n);
    check(16'(n < 2000), 16'h0001);
    rd(4'h6, d); check(d, 16'h0005);
    rd(4'h7, d); check(d, 16'h0005);
    $display("external count and capture done");
    // Capture on compare matches, then pin-rise-only capture while stopped
    wr(4'h0, 16'h0000);
    wr(4'h4, 16'h0002);
    wr(4'h5, 16'h0006);
    wr(4'h2, 16'h005d);
    wr(4'h0, 16'h0001);
    wait_irq(3, n);
    rd(4'h6, d); check(d, 16'h0002);
    rd(4'h7, d); check(d, 16'h0006);
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0048);
    cap_pin <= 1'b1;
    wait_irq(2, n);
    check(16'(n < 2000), 16'h0001);
    cap_pin <= 1'b0;
    wait_irq(3, n);
    check(16'(n), 16'h07d0);
    rd(4'h6, d); check(d, 16'h0000);
    $display("match capture done");
    report_and_stop();
  end
endmodule
`default_nettype wire
